// File: design/fqet_query_table.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
// Summary of operation
// R1 - Table tag bytes 50, 52, 49 hex returned at query addresses 10A, 10B, 10C.
// R2 - Major version character 31 hex returned at query address 10D.
// R3 - Minor version character 35 hex returned at query address 10E.
// R4 - Four-byte feature field, low byte first, at 10F to 112; first bytes E6, 01.
// R5 - Feature bits 11 through 29 are reserved and read as zero.
// R6 - Feature bit 31 set means a further 31-bit feature field follows; host parses it.
// R7 - Feature bit 0 reads zero: whole-chip erase not offered.
// R8 - Feature bit 1 reads one: erase may be suspended.
// R9 - Feature bit 2 reads one: program may be suspended.
// R10 - Feature bit 3 reads zero: older lock scheme not offered.
// R11 - Feature bit 4 reads zero: queued erase not offered.
// R12 - Feature bit 5 reads one: instant individual block locking.
// R13 - Feature bit 6 reads one: one-time-programmable bits available.
// R14 - Feature bit 7 reads one: page-mode reads supported.
// R15 - Feature bit 8 reads one: synchronous reads supported.
// R16 - Erase region entry: bits 0-15 block count minus one, bits 16-31 size in 256-byte units.
// R17 - Each query byte sits on data bits 7:0 with the upper bits zero.
module fqet_query_table #(
   parameter logic [15:0] region1_count_m1 = 16'h01fe,
   parameter logic [15:0] region1_size = 16'h0200,
   parameter logic [15:0] region2_count_m1 = 16'h0003,
   parameter logic [15:0] region2_size = 16'h0080,
   parameter logic feature_links = 1'b0,
   parameter logic feature_more = 1'b0,
   parameter logic [30:0] feature_next = 31'h0000_0000
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   initial begin
      if (feature_more == 1'b0 && feature_next != 31'h0000_0000) begin
         $error("feature_next is served only when feature_more is set");
      end
   end

   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic query_en_q;
   logic [9:0] last_idx_q;

   wire [31:0] feature_field;
   wire [31:0] next_field;
   wire [31:0] region1_entry;
   wire [31:0] region2_entry;
   wire [9:0] idx;
   wire aligned;
   wire access;
   wire take;

   // Fixed table bits are built from named positions so each meaning stays visible
   assign feature_field[fqet_pkg::feat_chip_erase] = 1'b0; // R7
   assign feature_field[fqet_pkg::feat_erase_suspend] = 1'b1; // R8
   assign feature_field[fqet_pkg::feat_program_suspend] = 1'b1; // R9
   assign feature_field[fqet_pkg::feat_legacy_lock] = 1'b0; // R10
   assign feature_field[fqet_pkg::feat_queued_erase] = 1'b0; // R11
   assign feature_field[fqet_pkg::feat_instant_lock] = 1'b1; // R12
   assign feature_field[fqet_pkg::feat_otp] = 1'b1; // R13
   assign feature_field[fqet_pkg::feat_page_read] = 1'b1; // R14
   assign feature_field[fqet_pkg::feat_sync_read] = 1'b1; // R15
   // Simultaneous operation and extended array block are not offered
   assign feature_field[fqet_pkg::feat_rsvd_lo - 1:fqet_pkg::feat_sync_read + 1] = 2'b00;
   assign feature_field[fqet_pkg::feat_rsvd_hi:fqet_pkg::feat_rsvd_lo] = 19'h0_0000; // R5
   assign feature_field[fqet_pkg::feat_links] = feature_links;
   assign feature_field[fqet_pkg::feat_more] = feature_more; // R6
   assign next_field = {1'b0, feature_next};

   assign region1_entry = {region1_size, region1_count_m1}; // R16
   assign region2_entry = {region2_size, region2_count_m1}; // R16

   assign idx = paddr[11:2];
   assign aligned = (paddr[1:0] == 2'b00) && (paddr[31:12] == 20'h0_0000);
   assign access = psel && penable && !pready_q;

   wire hit_ctrl = aligned && (idx == fqet_pkg::idx_query_ctrl);
   // A control write without its low byte strobe is ignored rather than refused
   assign take = access && pwrite && hit_ctrl && (pstrb[0] == 1'b1);
   wire hit_status = aligned && (idx == fqet_pkg::idx_query_status);
   wire hit_region = aligned && (idx >= fqet_pkg::idx_region1) && (idx <= fqet_pkg::idx_region_end);
   wire hit_ext = aligned && (idx >= fqet_pkg::idx_tag_char0) && (idx < fqet_pkg::idx_feature_next);
   // The extra field exists only while the continuation bit says so
   wire hit_next = aligned && feature_more && (idx >= fqet_pkg::idx_feature_next) &&
      (idx < fqet_pkg::idx_feature_next + 10'h004); // R6
   wire hit_table = hit_region || hit_ext || hit_next;
   wire [1:0] feat_lane = 2'(idx - fqet_pkg::idx_feature);
   wire [1:0] next_lane = 2'(idx - fqet_pkg::idx_feature_next);
   wire [1:0] reg1_lane = 2'(idx - fqet_pkg::idx_region1);
   wire [1:0] reg2_lane = 2'(idx - fqet_pkg::idx_region2);

   logic [7:0] table_byte;
   always_comb begin
      if (idx == fqet_pkg::idx_tag_char0) begin
         table_byte = fqet_pkg::tag_char0_val; // R1
      end else if (idx == fqet_pkg::idx_tag_char1) begin
         table_byte = fqet_pkg::tag_char1_val; // R1
      end else if (idx == fqet_pkg::idx_tag_char2) begin
         table_byte = fqet_pkg::tag_char2_val; // R1
      end else if (idx == fqet_pkg::idx_major_version) begin
         table_byte = fqet_pkg::major_version_val; // R2
      end else if (idx == fqet_pkg::idx_minor_version) begin
         table_byte = fqet_pkg::minor_version_val; // R3
      end else if (idx >= fqet_pkg::idx_feature && idx < fqet_pkg::idx_feature_next) begin
         table_byte = feature_field[{feat_lane, 3'b000} +: 8]; // R4
      end else if (hit_next) begin
         table_byte = next_field[{next_lane, 3'b000} +: 8]; // R6
      end else if (idx >= fqet_pkg::idx_region1 && idx < fqet_pkg::idx_region2) begin
         table_byte = region1_entry[{reg1_lane, 3'b000} +: 8]; // R16
      end else if (idx >= fqet_pkg::idx_region2 && idx < fqet_pkg::idx_region_rsvd) begin
         table_byte = region2_entry[{reg2_lane, 3'b000} +: 8]; // R16
      end else begin
         table_byte = 8'h00;
      end
   end

   // Table reads out of query mode return zero so stale array data is never mistaken for it
   wire [31:0] table_word = query_en_q ? {24'h00_0000, table_byte} : 32'h0000_0000; // R17
   wire [31:0] ctrl_word = {31'h0000_0000, query_en_q};
   wire [31:0] status_word = {22'h00_0000, last_idx_q};
   wire [31:0] read_word = hit_table ? table_word :
      hit_ctrl ? ctrl_word :
      hit_status ? status_word : 32'h0000_0000;
   // Table and status are read-only; a write there or any unmapped access is an error
   wire bad = !(hit_ctrl || (!pwrite && (hit_table || hit_status)));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= access;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (access) begin
         prdata_q <= pwrite ? 32'h0000_0000 : read_word;
         pslverr_q <= bad;
      end else begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         query_en_q <= fqet_pkg::ctrl_query_en_rst;
      end else if (take) begin
         query_en_q <= pwdata[fqet_pkg::ctrl_query_en];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_idx_q <= 10'h000;
      end else if (access && !pwrite && hit_table && query_en_q) begin
         last_idx_q <= idx;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
endmodule

// File: design/fqet_pkg.sv
package fqet_pkg;
   localparam int unsigned data_w = 32;
   localparam int unsigned idx_w = 10;

   // Word index of each table byte; the byte address on the bus is four times the index
   localparam logic [9:0] idx_region1 = 10'h02d;
   localparam logic [9:0] idx_region2 = 10'h031;
   localparam logic [9:0] idx_region_rsvd = 10'h035;
   localparam logic [9:0] idx_region_end = 10'h038;
   localparam logic [9:0] idx_tag_char0 = 10'h10a;
   localparam logic [9:0] idx_tag_char1 = 10'h10b;
   localparam logic [9:0] idx_tag_char2 = 10'h10c;
   localparam logic [9:0] idx_major_version = 10'h10d;
   localparam logic [9:0] idx_minor_version = 10'h10e;
   localparam logic [9:0] idx_feature = 10'h10f;
   localparam logic [9:0] idx_feature_next = 10'h113;
   localparam logic [9:0] idx_query_ctrl = 10'h200;
   localparam logic [9:0] idx_query_status = 10'h201;

   localparam logic [7:0] tag_char0_val = 8'h50;
   localparam logic [7:0] tag_char1_val = 8'h52;
   localparam logic [7:0] tag_char2_val = 8'h49;
   localparam logic [7:0] major_version_val = 8'h31;
   localparam logic [7:0] minor_version_val = 8'h35;

   // Feature bit positions
   localparam int unsigned feat_chip_erase = 0;
   localparam int unsigned feat_erase_suspend = 1;
   localparam int unsigned feat_program_suspend = 2;
   localparam int unsigned feat_legacy_lock = 3;
   localparam int unsigned feat_queued_erase = 4;
   localparam int unsigned feat_instant_lock = 5;
   localparam int unsigned feat_otp = 6;
   localparam int unsigned feat_page_read = 7;
   localparam int unsigned feat_sync_read = 8;
   localparam int unsigned feat_rsvd_lo = 11;
   localparam int unsigned feat_rsvd_hi = 29;
   localparam int unsigned feat_links = 30;
   localparam int unsigned feat_more = 31;

   localparam int unsigned region_count_lsb = 0;
   localparam int unsigned region_size_lsb = 16;

   // Control register fields
   localparam int unsigned ctrl_query_en = 0;
   localparam logic ctrl_query_en_rst = 1'b1;
endpackage

// File: testbench/fqet_query_table_checker.sv
`timescale 1ns/10ps
module fqet_query_table_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence setup_then_access;
      psel && !penable ##1 psel && penable;
   endsequence
   sequence read_done(a);
      pready && !pwrite && paddr == a;
   endsequence
   a_one_wait: assert property (setup_then_access |=> pready) else $error("no answer after one wait state");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr) else $error("outputs not quiet");
   a_upper_zero: assert property (pready && !pwrite && paddr < 32'h800 |-> prdata[31:8] == 24'h0)
      else $error("upper data lines not zero");
   a_tag_first: assert property (read_done(32'h428) |-> prdata inside {32'h50, 32'h0})
      else $error("wrong first tag char");
   a_feat_low: assert property (read_done(32'h43c) |-> prdata inside {32'he6, 32'h0})
      else $error("wrong feature low byte");
   a_reserved_zero: assert property (read_done(32'h444) |-> prdata == 32'h0 && !pslverr)
      else $error("reserved feature byte not zero");
   a_write_refused: assert property (pready && pwrite && paddr == 32'h428 |-> pslverr) else $error("table write taken");
endmodule

// File: testbench/fqet_host.sv
`timescale 1ns/10ps
module fqet_host (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
   // Request stays frozen until pready is sampled high, for at most 16 cycles; no fixed slave latency is assumed
   task automatic xfer(input logic w, input logic [31:0] a, d, input logic [3:0] s, output logic [31:0] rd,
                       output logic err, hung);
      hung = 1'b1;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
      @(posedge pclk);
      penable <= 1'b1;
      for (int n = 0; n < 16 && hung; n++) begin
         @(posedge pclk);
         if (pready)
            {rd, err, hung} = {prdata, pslverr, 1'b0};
      end
      {psel, penable} <= 2'b00;
   endtask
endmodule

// File: testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, err, hung;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [3:0] pstrb;
   int failures = 0;
   int num_checks = 0;
   // Erase regions first, then the extended table
   logic [7:0] bytes [21] = '{8'hfe, 8'h01, 8'h00, 8'h02, 8'h03, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h50, 8'h52, 8'h49, 8'h31, 8'h35, 8'he6, 8'h01, 8'h00, 8'h00};
   initial forever #50 pclk = ~pclk;
   fqet_query_table i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   fqet_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic acc(input logic w, input logic [9:0] idx, input logic [31:0] d, input logic [3:0] s,
                      input logic [31:0] exp, input logic exp_err);
      i_host.xfer(w, {20'h0, idx, 2'b00}, d, s, rd, err, hung);
      if (hung) begin
         failures++;
         print_verdict();
      end
      if (!w)
         check("prdata", rd, exp);
      check("pslverr", {31'h0, err}, {31'h0, exp_err});
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 21; i++)
         acc(1'b0, 10'(i < 12 ? 32'h2d + i : 32'hfe + i), 32'h0, 4'h0, {24'h0, bytes[i]}, 1'b0);
      acc(1'b0, 10'h113, 32'h0, 4'h0, 32'h0, 1'b1);
      acc(1'b1, 10'h10a, 32'h0, 4'hf, 32'h0, 1'b1);
      acc(1'b0, 10'h039, 32'h0, 4'h0, 32'h0, 1'b1);
      acc(1'b1, 10'h200, 32'h0, 4'h0, 32'h0, 1'b0);
      acc(1'b0, 10'h200, 32'h0, 4'h0, 32'h1, 1'b0);
      acc(1'b1, 10'h200, 32'h0, 4'h1, 32'h0, 1'b0);
      acc(1'b0, 10'h10f, 32'h0, 4'h0, 32'h0, 1'b0);
      acc(1'b1, 10'h200, 32'h1, 4'h1, 32'h0, 1'b0);
      acc(1'b0, 10'h10f, 32'h0, 4'h0, 32'he6, 1'b0);
      acc(1'b0, 10'h201, 32'h0, 4'h0, 32'h10f, 1'b0);
      acc(1'b1, 10'h201, 32'h0, 4'hf, 32'h0, 1'b1);
      print_verdict();
   end
endmodule
bind fqet_query_table fqet_query_table_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
